/* rtl/debug_and_reset_pin_mux.sv */
// debug and reset pin multiplexer with its ahb-lite register slave
`timescale 1ns/1ns
// Behaviour
// - debug pins start as debug; writing bit 6 low requests their release
// - released debug clock pin becomes port1 bit8, data pin port1 bit9
// - for 30 ms after power-on both debug pins stay debug
// - an early write waits until the oscillator-timed 30 ms window ends
// - in debug role both pull-ups stay on regardless of software
// - in gpio role pull-ups follow port1 pull-up bits 8 and 9
// - in debug role data pin direction follows the probe and the clock pin is input; in gpio role both follow gpio
// - once released, the probe port is disabled: no debug or download
// - reset pin is active-low reset by default; bit 5 high makes port0 bit2
// - in reset role execution is held while the reset pin is low
// - in gpio role the pin never resets; only power or watchdog do
// - reset pin multiplexing leaves the debug port working
module debug_and_reset_pin_mux #(
  parameter int LOCK_TICKS = pin_mux_pkg::LOCK_TICKS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // low-speed oscillator
  input  wire logic        low_speed_rc_osc,
  // debug clock pin
  input  wire logic        port1_bit8_pin_i,
  output logic             port1_bit8_pin_o,
  output logic             port1_bit8_pin_oe,
  output logic             port1_bit8_pin_pu,
  // debug data pin
  input  wire logic        port1_bit9_pin_i,
  output logic             port1_bit9_pin_o,
  output logic             port1_bit9_pin_oe,
  output logic             port1_bit9_pin_pu,
  // external reset pin
  input  wire logic        port0_bit2_pin_i,
  output logic             port0_bit2_pin_o,
  output logic             port0_bit2_pin_oe,
  output logic             port0_bit2_pin_pu,
  // debug port side
  output logic             swd_clk,
  output logic             swd_dio_in,
  input  wire logic        swd_dio_out,
  input  wire logic        swd_dio_oe,
  output logic             debug_enable,
  // gpio controller side
  input  wire logic        gpio_p18_out,
  input  wire logic        gpio_p18_oe,
  input  wire logic        gpio_p19_out,
  input  wire logic        gpio_p19_oe,
  input  wire logic        gpio_p02_out,
  input  wire logic        gpio_p02_oe,
  input  wire logic        gpio_p02_pu,
  output logic             gpio_p18_in,
  output logic             gpio_p19_in,
  output logic             gpio_p02_in,
  // reset controller side
  output logic             ext_reset_hold
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    logic                             wr_pend;
    logic [pin_mux_pkg::ADDR_W-1:0]   wr_addr;
    logic                             dbg_keep;
    logic                             rst_mux;
    logic [1:0]                       pue;
    logic                             dbg_gpio;
    logic [31:0]                      rdata;
    logic [pin_mux_pkg::NUM_PINS-1:0] s1;
    logic [pin_mux_pkg::NUM_PINS-1:0] s2;
    logic                             lrc1;
    logic                             lrc2;
    logic                             p8_o;
    logic                             p8_oe;
    logic                             p8_pu;
    logic                             p9_o;
    logic                             p9_oe;
    logic                             p9_pu;
    logic                             p2_o;
    logic                             p2_oe;
    logic                             p2_pu;
  } state_t;

  state_t q;
  state_t d;

  lock_if lk ();

  logic                           addr_take;
  logic [pin_mux_pkg::ADDR_W-1:0] addr_lo;

  // --------------------------------------------------------------
  // address decode helper
  // --------------------------------------------------------------
  function automatic logic word_hit(
    input logic [pin_mux_pkg::ADDR_W-1:0] a,
    input logic [pin_mux_pkg::ADDR_W-1:0] off
  );
    word_hit = (a == off);
  endfunction : word_hit

  // --------------------------------------------------------------
  // lock window timer
  // --------------------------------------------------------------
  lock_window_timer #(
    .LOCK_TICKS (LOCK_TICKS)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lk      (lk)
  );

  assign lk.lrc_level = q.lrc2;

  // address phase accepted when selected, ready and active
  assign addr_take = hsel && hready && htrans[pin_mux_pkg::HTRANS_ACTIVE];
  assign addr_lo   = haddr[pin_mux_pkg::ADDR_W-1:0];

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb begin
    d = q;

    // two-flop synchronisers for pins and oscillator
    d.s1   = {port0_bit2_pin_i, port1_bit9_pin_i, port1_bit8_pin_i};
    d.s2   = q.s1;
    d.lrc1 = low_speed_rc_osc;
    d.lrc2 = q.lrc1;

    // data phase of a write stores into the registers
    d.wr_pend = 1'b0;
    if (q.wr_pend) begin
      if (word_hit(q.wr_addr, pin_mux_pkg::OFF_PIN_CFG)) begin
        d.dbg_keep = hwdata[pin_mux_pkg::BIT_DBG_KEEP];
        d.rst_mux  = hwdata[pin_mux_pkg::BIT_RST_MUX];
      end else if (word_hit(q.wr_addr, pin_mux_pkg::OFF_PULLUP)) begin
        d.pue = {hwdata[pin_mux_pkg::BIT_PU_DAT],
                 hwdata[pin_mux_pkg::BIT_PU_CLK]};
      end
    end

    // address phase: latch writes, fetch config and pull-up reads from updated values, status from current state
    if (addr_take) begin
      d.wr_pend = hwrite;
      d.wr_addr = addr_lo;
      d.rdata   = '0;
      if (!hwrite) begin
        if (word_hit(addr_lo, pin_mux_pkg::OFF_PIN_CFG)) begin
          d.rdata[pin_mux_pkg::BIT_DBG_KEEP] = d.dbg_keep;
          d.rdata[pin_mux_pkg::BIT_RST_MUX]  = d.rst_mux;
        end else if (word_hit(addr_lo, pin_mux_pkg::OFF_PULLUP)) begin
          d.rdata[pin_mux_pkg::BIT_PU_CLK] = d.pue[0];
          d.rdata[pin_mux_pkg::BIT_PU_DAT] = d.pue[1];
        end else if (word_hit(addr_lo, pin_mux_pkg::OFF_STATUS)) begin
          d.rdata[pin_mux_pkg::BIT_ST_LOCK]      = lk.lock_elapsed;
          d.rdata[pin_mux_pkg::BIT_ST_DBG_GPIO]  = q.dbg_gpio;
          d.rdata[pin_mux_pkg::BIT_ST_RST_GPIO]  = q.rst_mux;
          d.rdata[pin_mux_pkg::BIT_ST_RST_LEVEL] = q.s2[pin_mux_pkg::PIN_RST];
        end
      end
    end

    // release of the debug pins waits for the lock window
    d.dbg_gpio = !q.dbg_keep && lk.lock_elapsed;

    // debug clock pin
    if (q.dbg_gpio) begin
      d.p8_o  = gpio_p18_out;
      d.p8_oe = gpio_p18_oe;
      d.p8_pu = q.pue[0];
    end else begin
      d.p8_o  = 1'b0;
      d.p8_oe = 1'b0;
      d.p8_pu = 1'b1;
    end

    // debug data pin
    if (q.dbg_gpio) begin
      d.p9_o  = gpio_p19_out;
      d.p9_oe = gpio_p19_oe;
      d.p9_pu = q.pue[1];
    end else begin
      d.p9_o  = swd_dio_out;
      d.p9_oe = swd_dio_oe;
      d.p9_pu = 1'b1;
    end

    // reset pin
    if (q.rst_mux) begin
      d.p2_o  = gpio_p02_out;
      d.p2_oe = gpio_p02_oe;
      d.p2_pu = gpio_p02_pu;
    end else begin
      d.p2_o  = 1'b0;
      d.p2_oe = 1'b0;
      d.p2_pu = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // state register; selection bits back to defaults on hard reset
  // --------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.dbg_keep <= pin_mux_pkg::DBG_KEEP_RESET;
      q.rst_mux  <= pin_mux_pkg::RST_MUX_RESET;
      q.pue      <= pin_mux_pkg::PULLUP_RESET;
      q.s1       <= '1;
      q.s2       <= '1;
      q.p8_pu    <= 1'b1;
      q.p9_pu    <= 1'b1;
      q.p2_pu    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = pin_mux_pkg::HRESP_OKAY;
  assign hrdata    = q.rdata;

  assign port1_bit8_pin_o  = q.p8_o;
  assign port1_bit8_pin_oe = q.p8_oe;
  assign port1_bit8_pin_pu = q.p8_pu;
  assign port1_bit9_pin_o  = q.p9_o;
  assign port1_bit9_pin_oe = q.p9_oe;
  assign port1_bit9_pin_pu = q.p9_pu;
  assign port0_bit2_pin_o  = q.p2_o;
  assign port0_bit2_pin_oe = q.p2_oe;
  assign port0_bit2_pin_pu = q.p2_pu;

  // synchronised pin levels for both consumers
  assign swd_clk     = q.s2[pin_mux_pkg::PIN_CLK];
  assign swd_dio_in  = q.s2[pin_mux_pkg::PIN_DAT];
  assign gpio_p18_in = q.s2[pin_mux_pkg::PIN_CLK];
  assign gpio_p19_in = q.s2[pin_mux_pkg::PIN_DAT];
  assign gpio_p02_in = q.s2[pin_mux_pkg::PIN_RST];

  // probe port cut off once the debug pins are released
  assign debug_enable = !q.dbg_gpio;

  // low reset pin holds the core, only in the reset role
  assign ext_reset_hold = !q.rst_mux && !q.s2[pin_mux_pkg::PIN_RST];

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  chk_cfg_dbg_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.wr_pend && word_hit(q.wr_addr, pin_mux_pkg::OFF_PIN_CFG)
    |=> q.dbg_keep == $past(hwdata[pin_mux_pkg::BIT_DBG_KEEP]))
    else $error("debug keep bit not written");

  chk_gpio_handover: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.dbg_gpio |=> port1_bit9_pin_o == $past(gpio_p19_out)
                && port1_bit8_pin_oe == $past(gpio_p18_oe))
    else $error("released debug pins not driven by gpio");

  chk_lock_window_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !lk.lock_elapsed |=> !q.dbg_gpio)
    else $error("debug pins released inside lock window");

  chk_release_after_lock: assert property (
    @(posedge hclk) disable iff (!hresetn)
    lk.lock_elapsed && !q.dbg_keep |=> q.dbg_gpio)
    else $error("debug pins not released after lock window");

  chk_dbg_pullup_on: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !q.dbg_gpio |=> port1_bit8_pin_pu && port1_bit9_pin_pu)
    else $error("pull-up off in debug role");

  chk_gpio_pullup_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.dbg_gpio |=> port1_bit8_pin_pu == $past(q.pue[0])
                && port1_bit9_pin_pu == $past(q.pue[1]))
    else $error("gpio pull-up ignores enable bits");

  chk_swd_direction: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !q.dbg_gpio |=> !port1_bit8_pin_oe
                 && port1_bit9_pin_oe == $past(swd_dio_oe))
    else $error("debug pin direction wrong");

  chk_probe_cutoff: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.dbg_gpio |-> !debug_enable)
    else $error("probe port alive after release");

  chk_rst_pin_role: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !q.rst_mux && !q.s2[pin_mux_pkg::PIN_RST] |-> ext_reset_hold)
    else $error("low reset pin does not hold the core");

  chk_rst_gpio_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.rst_mux |-> !ext_reset_hold)
    else $error("reset from pin in gpio role");

  chk_rst_mux_debug_ok: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.rst_mux && !q.dbg_gpio |-> debug_enable)
    else $error("reset pin mux disabled debug");

  chk_cfg_rst_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.wr_pend && word_hit(q.wr_addr, pin_mux_pkg::OFF_PIN_CFG)
    |=> q.rst_mux == $past(hwdata[pin_mux_pkg::BIT_RST_MUX]))
    else $error("reset mux bit not written");

  chk_pullup_write: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.wr_pend && word_hit(q.wr_addr, pin_mux_pkg::OFF_PULLUP)
    |=> q.pue[0] == $past(hwdata[pin_mux_pkg::BIT_PU_CLK])
     && q.pue[1] == $past(hwdata[pin_mux_pkg::BIT_PU_DAT]))
    else $error("pull-up enable bits not written");

  chk_rst_pin_input: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !q.rst_mux |=> !port0_bit2_pin_oe && port0_bit2_pin_pu)
    else $error("reset pin not a pulled-up input");

  chk_rst_gpio_drive: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.rst_mux |=> port0_bit2_pin_o == $past(gpio_p02_out)
               && port0_bit2_pin_oe == $past(gpio_p02_oe))
    else $error("gpio does not drive the reset pin");

  chk_rst_release: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.s2[pin_mux_pkg::PIN_RST] |-> !ext_reset_hold)
    else $error("core held with reset pin high");

endmodule : debug_and_reset_pin_mux

/* rtl/lock_if.sv */
// carrier between the pin multiplexer and its lock window timer
`timescale 1ns/1ns
interface lock_if;
  logic lrc_level;    // synchronised oscillator level
  logic lock_elapsed; // lock window over, sticky

  modport owner (output lrc_level, input lock_elapsed);
  modport timer (input lrc_level, output lock_elapsed);
endinterface : lock_if

/* rtl/lock_window_timer.sv */
// counts low-speed oscillator periods to end the power-on lock window
`timescale 1ns/1ns
module lock_window_timer #(
  parameter int LOCK_TICKS = pin_mux_pkg::LOCK_TICKS
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  lock_if.timer     lk
);

  typedef struct packed {
    logic                          prev;
    logic [pin_mux_pkg::CNT_W-1:0] cnt;
    logic                          done;
  } tmr_t;

  tmr_t q;
  tmr_t d;

  localparam logic [pin_mux_pkg::CNT_W-1:0] LAST =
    pin_mux_pkg::CNT_W'(LOCK_TICKS - 1);

  // --------------------------------------------------------------
  // rising edges of the oscillator advance the count
  // --------------------------------------------------------------
  always_comb begin
    d      = q;
    d.prev = lk.lrc_level;
    if (lk.lrc_level && !q.prev && !q.done) begin
      if (q.cnt == LAST) begin
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lk.lock_elapsed = q.done;

  chk_lock_sticky_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    q.done |=> q.done)
    else $error("lock window flag dropped");

  chk_lock_no_early: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (q.cnt != LAST) |=> !$rose(q.done))
    else $error("lock window ended before the last tick");

endmodule : lock_window_timer

/* rtl/pin_mux_pkg.sv */
// constants shared by the debug and reset pin multiplexer
package pin_mux_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, low address bits decoded)
  // ---------------------------------------------------------------
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFF_PIN_CFG      = 8'h00;
  localparam logic [7:0]  OFF_PULLUP       = 8'h04;
  localparam logic [7:0]  OFF_STATUS       = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          BIT_RST_MUX      = 5;
  localparam int          BIT_DBG_KEEP     = 6;
  localparam int          BIT_PU_CLK       = 8;
  localparam int          BIT_PU_DAT       = 9;
  localparam int          BIT_ST_LOCK      = 0;
  localparam int          BIT_ST_DBG_GPIO  = 1;
  localparam int          BIT_ST_RST_GPIO  = 2;
  localparam int          BIT_ST_RST_LEVEL = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic        DBG_KEEP_RESET   = 1'b1;
  localparam logic        RST_MUX_RESET    = 1'b0;
  localparam logic [1:0]  PULLUP_RESET     = 2'h0;

  // ---------------------------------------------------------------
  // pin slots in the synchroniser vectors
  // ---------------------------------------------------------------
  localparam int          PIN_CLK          = 0;
  localparam int          PIN_DAT          = 1;
  localparam int          PIN_RST          = 2;
  localparam int          NUM_PINS         = 3;

  // ---------------------------------------------------------------
  // power-on lock window, counted in low-speed oscillator periods
  // ---------------------------------------------------------------
  localparam int          LOCK_TIME_MS     = 30;
  localparam int          LRC_FREQ_HZ      = 64000;
  localparam int          MS_PER_S         = 1000;
  localparam int          LOCK_TICKS       = LOCK_TIME_MS * LRC_FREQ_HZ / MS_PER_S;
  localparam int          CNT_W            = 16;

  // ---------------------------------------------------------------
  // ahb-lite codes
  // ---------------------------------------------------------------
  localparam logic        HRESP_OKAY       = 1'b0;
  localparam int          HTRANS_ACTIVE    = 1;

endpackage : pin_mux_pkg

/* tb/probe_model.sv */
// debug probe and board reset circuit at the far side of the pins
`timescale 1ns/1ns
module probe_model (
  input  wire logic hclk,
  input  wire logic clk_run,
  input  wire logic dio_drv,
  input  wire logic dio_val,
  input  wire logic rst_low,
  input  wire logic p8_o,
  input  wire logic p8_oe,
  input  wire logic p8_pu,
  input  wire logic p9_o,
  input  wire logic p9_oe,
  input  wire logic p9_pu,
  input  wire logic p2_o,
  input  wire logic p2_oe,
  input  wire logic p2_pu,
  output logic      p8_i,
  output logic      p9_i,
  output logic      p2_i
);
  logic swclk_q = 1'b0;
  logic l8_q    = 1'b1;
  logic l9_q    = 1'b1;
  logic l2_q    = 1'b1;

  // probe clock runs only inside a frame; last levels kept for floating lines
  always_ff @(posedge hclk) begin
    swclk_q <= clk_run & ~swclk_q;
    l8_q    <= p8_i;
    l9_q    <= p9_i;
    l2_q    <= p2_i;
  end

  // wire levels: device driver, then probe or board, then pull-up, else drifting
  always_comb begin
    p8_i = p8_oe ? p8_o : (clk_run ? swclk_q : (p8_pu ? 1'b1 : ~l8_q));
    p9_i = p9_oe ? p9_o : (dio_drv ? dio_val : (p9_pu ? 1'b1 : ~l9_q));
    p2_i = p2_oe ? p2_o : (rst_low ? 1'b0 : (p2_pu ? 1'b1 : ~l2_q));
  end
endmodule : probe_model

/* tb/tb.sv */
// self-checking bench for the debug and reset pin multiplexer
`timescale 1ns/1ns
module tb;
  localparam int TICKS = 4;
  localparam int LIMIT = 5000;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, low_speed_rc_osc;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [1:0]  osc_div;
  logic        port1_bit8_pin_i, port1_bit8_pin_o, port1_bit8_pin_oe, port1_bit8_pin_pu;
  logic        port1_bit9_pin_i, port1_bit9_pin_o, port1_bit9_pin_oe, port1_bit9_pin_pu;
  logic        port0_bit2_pin_i, port0_bit2_pin_o, port0_bit2_pin_oe, port0_bit2_pin_pu;
  logic        swd_clk, swd_dio_in, swd_dio_out, swd_dio_oe, debug_enable, ext_reset_hold;
  logic        gpio_p18_out, gpio_p18_oe, gpio_p19_out, gpio_p19_oe;
  logic        gpio_p02_out, gpio_p02_oe, gpio_p02_pu, gpio_p18_in, gpio_p19_in, gpio_p02_in;
  logic        clk_run, dio_drv, dio_val, rst_low, osc_run;
  int          err_count, comparisons, cycles;

  debug_and_reset_pin_mux #(.LOCK_TICKS(TICKS)) i_debug_and_reset_pin_mux (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .low_speed_rc_osc,
    .port1_bit8_pin_i, .port1_bit8_pin_o, .port1_bit8_pin_oe, .port1_bit8_pin_pu,
    .port1_bit9_pin_i, .port1_bit9_pin_o, .port1_bit9_pin_oe, .port1_bit9_pin_pu,
    .port0_bit2_pin_i, .port0_bit2_pin_o, .port0_bit2_pin_oe, .port0_bit2_pin_pu,
    .swd_clk, .swd_dio_in, .swd_dio_out, .swd_dio_oe, .debug_enable,
    .gpio_p18_out, .gpio_p18_oe, .gpio_p19_out, .gpio_p19_oe, .gpio_p02_out,
    .gpio_p02_oe, .gpio_p02_pu, .gpio_p18_in, .gpio_p19_in, .gpio_p02_in, .ext_reset_hold);

  probe_model i_probe_model (
    .hclk, .clk_run, .dio_drv, .dio_val, .rst_low,
    .p8_o(port1_bit8_pin_o), .p8_oe(port1_bit8_pin_oe), .p8_pu(port1_bit8_pin_pu),
    .p9_o(port1_bit9_pin_o), .p9_oe(port1_bit9_pin_oe), .p9_pu(port1_bit9_pin_pu),
    .p2_o(port0_bit2_pin_o), .p2_oe(port0_bit2_pin_oe), .p2_pu(port0_bit2_pin_pu),
    .p8_i(port1_bit8_pin_i), .p9_i(port1_bit9_pin_i), .p2_i(port0_bit2_pin_i));

  // ---------------------------------------------------------------
  // clock, oscillator, timeout
  // ---------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // slow oscillator toggles every 4 hclk while enabled, cycle ceiling
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (osc_run) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) low_speed_rc_osc <= ~low_speed_rc_osc;
    end
    if (cycles == LIMIT) begin
      err_count++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(what, exp, v);
  endtask : rchk

  // let register updates reach the pins, then sample away from the edge
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  task automatic end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_defaults;
    rchk("config", pin_mux_pkg::OFF_PIN_CFG, 32'h40);
    rchk("pullup", pin_mux_pkg::OFF_PULLUP, 32'h0);
    rchk("status", pin_mux_pkg::OFF_STATUS, 32'h8);
    chk("okay resp", 32'h0, 32'(hresp));
    wr(pin_mux_pkg::OFF_PULLUP, 32'h0);
    settle(4);
    chk("clk pullup", 32'h1, 32'(port1_bit8_pin_pu));
    chk("dat pullup", 32'h1, 32'(port1_bit9_pin_pu));
    chk("rst pullup", 32'h1, 32'(port0_bit2_pin_pu));
    chk("clk dir", 32'h0, 32'(port1_bit8_pin_oe));
    wr(8'h0C, 32'hFFFF_FFFF);
    rchk("unmapped", 8'h0C, 32'h0);
    rchk("config kept", pin_mux_pkg::OFF_PIN_CFG, 32'h40);
    wr(pin_mux_pkg::OFF_PULLUP, 32'h300);
    rchk("pullup wr", pin_mux_pkg::OFF_PULLUP, 32'h300);
  endtask : t_defaults

  task automatic t_data_dir;
    @(posedge hclk);
    swd_dio_oe  <= 1'b1;
    swd_dio_out <= 1'b0;
    settle(3);
    chk("dat oe out", 32'h1, 32'(port1_bit9_pin_oe));
    chk("dat o", 32'h0, 32'(port1_bit9_pin_o));
    @(posedge hclk);
    swd_dio_oe <= 1'b0;
    dio_drv    <= 1'b1;
    dio_val    <= 1'b0;
    settle(4);
    chk("dat oe in", 32'h0, 32'(port1_bit9_pin_oe));
    chk("dat in", 32'h0, 32'(swd_dio_in));
    chk("clk idle", 32'h1, 32'(swd_clk));
    @(posedge hclk);
    dio_drv <= 1'b0;
    clk_run <= 1'b1;
    settle(4);
    chk("clk follow", 32'(port1_bit8_pin_i), 32'(swd_clk));
    @(posedge hclk);
    clk_run <= 1'b0;
  endtask : t_data_dir

  task automatic t_lock;
    int n;
    n = 0;
    // probe frames are over before the release is written
    wr(pin_mux_pkg::OFF_PIN_CFG, 32'h0);
    settle(20);
    chk("locked en", 32'h1, 32'(debug_enable));
    rchk("locked st", pin_mux_pkg::OFF_STATUS, 32'h8);
    @(posedge hclk);
    osc_run <= 1'b1;
    swd_dio_oe <= 1'b1;
    gpio_p18_oe <= 1'b1;
    while (debug_enable !== 1'b0 && n < 200) begin
      n++;
      @(posedge hclk);
    end
    chk("lock span", 32'h1, 32'(n >= (TICKS - 1) * 8 + 4 && n <= 60));
    settle(3);
    chk("probe off", 32'h0, 32'(debug_enable));
    chk("dat gpio oe", 32'h0, 32'(port1_bit9_pin_oe));
    chk("clk gpio oe", 32'h1, 32'(port1_bit8_pin_oe));
    chk("clk gpio in", 32'h0, 32'(gpio_p18_in));
    chk("dat gpio in", 32'h1, 32'(gpio_p19_in));
    rchk("released st", pin_mux_pkg::OFF_STATUS, 32'hB);
    wr(pin_mux_pkg::OFF_PULLUP, 32'h200);
    settle(4);
    chk("clk pu gpio", 32'h0, 32'(port1_bit8_pin_pu));
    chk("dat pu gpio", 32'h1, 32'(port1_bit9_pin_pu));
    @(posedge hclk);
    gpio_p18_oe <= 1'b0;
    swd_dio_oe  <= 1'b0;
    wr(pin_mux_pkg::OFF_PIN_CFG, 32'h40);
    settle(4);
    chk("debug back", 32'h1, 32'(debug_enable));
    chk("clk pu forced", 32'h1, 32'(port1_bit8_pin_pu));
  endtask : t_lock

  task automatic t_reset_pin;
    @(posedge hclk);
    rst_low <= 1'b1;
    settle(4);
    chk("hold", 32'h1, 32'(ext_reset_hold));
    wr(pin_mux_pkg::OFF_PIN_CFG, 32'h60);
    settle(4);
    chk("no hold", 32'h0, 32'(ext_reset_hold));
    chk("probe kept", 32'h1, 32'(debug_enable));
    rchk("rst gpio st", pin_mux_pkg::OFF_STATUS, 32'h5);
    @(posedge hclk);
    rst_low     <= 1'b0;
    gpio_p02_oe <= 1'b1;
    gpio_p02_out <= 1'b1;
    settle(4);
    chk("p02 oe", 32'h1, 32'(port0_bit2_pin_oe));
    chk("p02 pu", 32'h0, 32'(port0_bit2_pin_pu));
    chk("p02 o", 32'h1, 32'(port0_bit2_pin_o));
    chk("p02 in", 32'h1, 32'(gpio_p02_in));
  endtask : t_reset_pin

  task automatic t_hard_reset;
    @(posedge hclk);
    osc_run <= 1'b0;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rchk("cfg after reset", pin_mux_pkg::OFF_PIN_CFG, 32'h40);
    settle(4);
    chk("en after reset", 32'h1, 32'(debug_enable));
    chk("rst pu after", 32'h1, 32'(port0_bit2_pin_pu));
  endtask : t_hard_reset

  // main sequence
  initial begin
    {hresetn, hsel, hwrite, low_speed_rc_osc, swd_dio_out, swd_dio_oe} = '0;
    {gpio_p18_out, gpio_p18_oe, gpio_p19_out, gpio_p19_oe} = '0;
    {gpio_p02_out, gpio_p02_oe, gpio_p02_pu, clk_run, dio_drv, dio_val} = '0;
    {rst_low, osc_run, osc_div, htrans, haddr, hwdata} = '0;
    {err_count, comparisons, cycles} = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults();
    t_data_dir();
    t_lock();
    t_reset_pin();
    t_hard_reset();
    end_sim();
  end
endmodule : tb
